// [pcl_loader.sv]
// fast parallel configuration loader: sequencer and link-side word receiver
`timescale 1ns/10ps

// Overview of operation
// [R01] pulling cfg_request_n low in user mode drops user mode and starts a new configuration.
// [R02] in user mode the request, ready and load-complete lines all sit high.
// [R03] after power-up the ready line is held low for the whole power-on delay.
// [R04] load_complete stays low from power-up, before loading and during loading.
// [R05] once configuration has completed, cfg_clock activity is ignored.
// [R06] the host keeps cfg_clock at a defined level after configuration, high, low or toggling.
// [R07] the host may pause cfg_clock low and the loader keeps its progress until edges resume.
// [R08] after a pause the host puts valid data on the bus before the first rising edge.
// [R09] each word is held for r cfg_clock cycles and the loader takes one word per r cycles.
// [R10] the ratio r is picked from the decompression and security settings.
// [R11] the host sends the whole bitstream, first word to last.
// [R12] load_complete is released high only after the whole bitstream arrived without error.
// [R13] after load_complete rises two more falling cfg_clock edges start init and user mode.
// [R14] when the init-done option is loaded, the init-done pin is driven low until init ends.
// [R15] after a request and the reset delay the ready line is released high to accept data.
// [R16] data is sampled on rising cfg_clock edges and user I/O stays high-Z until user mode.
// [R17] the init-done pin goes high when user mode is entered.
module pcl_loader
  import pcl_pkg::*;
#(
  parameter int NUM_WORDS = 16,
  parameter int POR_DELAY_NS = 100000,
  parameter int RST_DELAY_NS = 2000,
  parameter int INIT_CYCLES = 8
) (
  input wire logic clk, // system clock, 200 MHz
  input wire logic rst, // async reset, active high
  input wire logic cfg_clock, // host configuration clock
  input wire logic cfg_request_n, // host configuration request, active low
  input wire logic [DATA_W-1:0] cfg_data, // configuration word from host
  input wire logic cfg_decompress, // decompression setting
  input wire logic cfg_secure, // design security setting
  input wire logic cfg_ready_n_i, // resolved ready line level
  output pcl_od_s cfg_ready_n_od, // ready line open-drain drive
  input wire logic load_complete_i, // resolved load-complete line level
  output pcl_od_s load_complete_od, // load-complete open-drain drive
  output pcl_od_s init_done_od, // init-done open-drain drive
  output logic user_mode, // device in user mode
  output logic user_io_oe_n // user I/O output enable, low drives
);

  // ----------------------------------------------------------------
  // derived counts
  // ----------------------------------------------------------------
  localparam int POR_CYC_I = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC_I = (RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] POR_CYC = CNT_W'(POR_CYC_I < 1 ? 1 : POR_CYC_I);
  localparam logic [CNT_W-1:0] RST_CYC = CNT_W'(RST_CYC_I < 1 ? 1 : RST_CYC_I);
  localparam logic [CNT_W-1:0] INIT_CYC = CNT_W'(INIT_CYCLES < 1 ? 1 : INIT_CYCLES);
  localparam logic [WCNT_W-1:0] LAST_WORD = WCNT_W'(NUM_WORDS - 1);

  // ----------------------------------------------------------------
  // system domain declarations
  // ----------------------------------------------------------------
  pcl_sys_s sys_ff;
  pcl_sys_s nxt_sys;
  logic [SY_W-1:0] sy_in;
  logic [SY_W-1:0] sy_q;

  // ----------------------------------------------------------------
  // link domain declarations
  // ----------------------------------------------------------------
  pcl_link_s lnk_ff;
  pcl_link_s nxt_lnk;
  logic [1:0] fall_ff;
  logic [1:0] nxt_fall;
  logic link_rst;
  logic [3:0] ratio;

  // ----------------------------------------------------------------
  // crossings into the system domain
  // ----------------------------------------------------------------
  // pins and link-domain levels all pass two flops before use
  always_comb begin
    sy_in = '0;
    sy_in[SY_REQ_N] = cfg_request_n;
    sy_in[SY_READY_LINE] = cfg_ready_n_i;
    sy_in[SY_DONE_LINE] = load_complete_i;
    sy_in[SY_LOADED] = lnk_ff.loaded;
    sy_in[SY_ERROR] = lnk_ff.error;
    sy_in[SY_INIT_GO] = (fall_ff == 2'h2);
    sy_in[SY_INIT_EN] = lnk_ff.init_en;
    sy_in[SY_DECOMP] = cfg_decompress;
    sy_in[SY_SECURE] = cfg_secure;
  end

  pcl_sync #(
    .WIDTH(SY_W),
    .RST_VAL(SY_RST_VAL)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d(sy_in),
    .q(sy_q)
  );

  // ----------------------------------------------------------------
  // state decodes
  // ----------------------------------------------------------------
  // states that keep the link in reset and pull the ready line low
  function automatic logic is_hold_state(input pcl_state_e st);
    logic h;
    h = 1'b0;
    case (st)
      ST_POR: begin
        h = 1'b1; // power-on delay
      end
      ST_RESET: begin
        h = 1'b1; // request still low
      end
      ST_DELAY: begin
        h = 1'b1; // reset delay running
      end
      ST_RELEASE: begin
        h = 1'b0;
      end
      ST_LOAD: begin
        h = 1'b0;
      end
      ST_INIT: begin
        h = 1'b0;
      end
      ST_USER: begin
        h = 1'b0;
      end
      ST_ERROR: begin
        h = 1'b1; // a failed load waits for a new request
      end
      default: begin
        h = 1'b1;
      end
    endcase
    return h;
  endfunction

  // states past a good load, in which load_complete stays released
  function automatic logic is_late_state(input pcl_state_e st);
    logic l;
    l = 1'b0;
    case (st)
      ST_POR: begin
        l = 1'b0;
      end
      ST_RESET: begin
        l = 1'b0;
      end
      ST_DELAY: begin
        l = 1'b0;
      end
      ST_RELEASE: begin
        l = 1'b0;
      end
      ST_LOAD: begin
        l = 1'b0; // released only once the check word matched
      end
      ST_INIT: begin
        l = 1'b1;
      end
      ST_USER: begin
        l = 1'b1;
      end
      ST_ERROR: begin
        l = 1'b0;
      end
      default: begin
        l = 1'b0;
      end
    endcase
    return l;
  endfunction

  // ----------------------------------------------------------------
  // system sequencer
  // ----------------------------------------------------------------
  // next-state and next-output logic of the sequencer
  always_comb begin
    nxt_sys = sys_ff;
    case (sys_ff.state)
      ST_POR: begin
        // power-on delay, ready held low throughout
        if (sys_ff.cnt == POR_CYC - 1'b1) begin // see [R03]
          nxt_sys.state = ST_RESET;
          nxt_sys.cnt = '0;
        end else begin
          nxt_sys.cnt = sys_ff.cnt + 1'b1;
        end
      end
      ST_RESET: begin
        nxt_sys.cnt = '0;
        if (sy_q[SY_REQ_N]) begin
          nxt_sys.state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        // settings are captured here and held static while loading
        nxt_sys.decomp = sy_q[SY_DECOMP]; // see [R10]
        nxt_sys.secure = sy_q[SY_SECURE]; // see [R10]
        if (sys_ff.cnt == RST_CYC - 1'b1) begin // see [R15]
          nxt_sys.state = ST_RELEASE;
          nxt_sys.cnt = '0;
        end else begin
          nxt_sys.cnt = sys_ff.cnt + 1'b1;
        end
      end
      ST_RELEASE: begin
        // wait for the shared ready line to read high
        if (sy_q[SY_READY_LINE]) begin
          nxt_sys.state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (sy_q[SY_ERROR]) begin
          nxt_sys.state = ST_ERROR;
        end else if (sy_q[SY_INIT_GO] && sy_q[SY_DONE_LINE]) begin // see [R13]
          nxt_sys.state = ST_INIT;
          nxt_sys.cnt = '0;
        end
      end
      ST_INIT: begin
        if (sys_ff.cnt == INIT_CYC - 1'b1) begin
          nxt_sys.state = ST_USER;
          nxt_sys.cnt = '0;
        end else begin
          nxt_sys.cnt = sys_ff.cnt + 1'b1;
        end
      end
      ST_USER: begin
        nxt_sys.cnt = '0;
      end
      ST_ERROR: begin
        nxt_sys.cnt = '0;
      end
      default: begin
        nxt_sys.state = ST_RESET;
        nxt_sys.cnt = '0;
      end
    endcase
    // a request low restarts configuration from any state past power-on
    if (sys_ff.state != ST_POR && !sy_q[SY_REQ_N]) begin // see [R01]
      nxt_sys.state = ST_RESET;
      nxt_sys.cnt = '0;
    end
    // registered pin drives decoded from the next state
    nxt_sys.hold = is_hold_state(nxt_sys.state);
    nxt_sys.ready_drv = is_hold_state(nxt_sys.state); // see [R03]
    nxt_sys.done_rel = ((nxt_sys.state == ST_LOAD) && sy_q[SY_LOADED]) ||
                       is_late_state(nxt_sys.state); // see [R04]
    nxt_sys.init_drv = sy_q[SY_INIT_EN] &&
                       ((nxt_sys.state == ST_LOAD) || (nxt_sys.state == ST_INIT)); // see [R14]
    nxt_sys.user = (nxt_sys.state == ST_USER); // see [R17]
  end

  // sequencer register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_ff <= '{state: ST_POR, cnt: '0, hold: 1'b1, decomp: 1'b0, secure: 1'b0,
                  ready_drv: 1'b1, done_rel: 1'b0, init_drv: 1'b0, user: 1'b0};
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  // ----------------------------------------------------------------
  // pin drives
  // ----------------------------------------------------------------
  // open-drain lines only ever pull low; released lines float high
  assign cfg_ready_n_od.o = 1'b0;
  assign cfg_ready_n_od.oe_n = ~sys_ff.ready_drv; // see [R02]
  assign load_complete_od.o = 1'b0;
  assign load_complete_od.oe_n = sys_ff.done_rel; // see [R12]
  assign init_done_od.o = 1'b0;
  assign init_done_od.oe_n = ~sys_ff.init_drv; // see [R17]
  assign user_mode = sys_ff.user;
  assign user_io_oe_n = ~sys_ff.user; // see [R16]

  // ----------------------------------------------------------------
  // link domain word receiver
  // ----------------------------------------------------------------
  // the hold level comes from a flop; cfg_clock is idle while it is
  // asserted, so its release needs no resynchronisation
  assign link_rst = sys_ff.hold;
  assign ratio = pcl_ratio(sys_ff.decomp, sys_ff.secure); // see [R10]

  // word capture, ratio counting and end-of-stream check
  always_comb begin
    nxt_lnk = lnk_ff;
    // once loaded or failed, further edges change nothing
    if (!lnk_ff.loaded && !lnk_ff.error) begin // see [R05]
      if (lnk_ff.phase == 4'h0) begin
        // first rising edge of each word period takes the word
        if (lnk_ff.words == OPT_WORD_IDX) begin
          nxt_lnk.init_en = cfg_data[OPT_INIT_DONE_BIT]; // see [R14]
        end
        if (lnk_ff.words == LAST_WORD) begin
          // last word carries the xor of all earlier words
          if (cfg_data == lnk_ff.sum) begin
            nxt_lnk.loaded = 1'b1; // see [R12]
          end else begin
            nxt_lnk.error = 1'b1;
          end
        end else begin
          nxt_lnk.sum = lnk_ff.sum ^ cfg_data; // see [R16]
          nxt_lnk.words = lnk_ff.words + 1'b1;
        end
      end
      // one word per r clock cycles
      if (lnk_ff.phase == ratio - 1'b1) begin // see [R09]
        nxt_lnk.phase = 4'h0;
      end else begin
        nxt_lnk.phase = lnk_ff.phase + 1'b1;
      end
    end
  end

  // receiver register; progress simply waits while the clock is paused
  always_ff @(posedge cfg_clock or posedge link_rst) begin // see [R07]
    if (link_rst) begin
      lnk_ff <= '{phase: 4'h0, words: '0, sum: '0, init_en: 1'b0, loaded: 1'b0,
                  error: 1'b0};
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  // ----------------------------------------------------------------
  // falling-edge counter after load completes
  // ----------------------------------------------------------------
  // saturates at two so later edges are ignored
  always_comb begin
    nxt_fall = fall_ff;
    if (lnk_ff.loaded && fall_ff != 2'h2) begin // see [R13]
      nxt_fall = fall_ff + 1'b1;
    end
  end

  always_ff @(negedge cfg_clock or posedge link_rst) begin
    if (link_rst) begin
      fall_ff <= 2'h0;
    end else begin
      fall_ff <= nxt_fall;
    end
  end

endmodule

// [pcl_pkg.sv]
// constants, types and helpers for the parallel configuration loader
package pcl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // data path and bitstream layout
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int WCNT_W = 16;
  localparam int OPT_INIT_DONE_BIT = 0;
  localparam logic [WCNT_W-1:0] OPT_WORD_IDX = 16'h0000;

  // clocks-per-word ratios by decompression / security setting
  localparam logic [3:0] RATIO_PLAIN = 4'h1;
  localparam logic [3:0] RATIO_DECOMP = 4'h2;
  localparam logic [3:0] RATIO_SECURE = 4'h2;
  localparam logic [3:0] RATIO_BOTH = 4'h4;

  // sync vector bit positions (system side)
  localparam int SY_REQ_N = 0;
  localparam int SY_READY_LINE = 1;
  localparam int SY_DONE_LINE = 2;
  localparam int SY_LOADED = 3;
  localparam int SY_ERROR = 4;
  localparam int SY_INIT_GO = 5;
  localparam int SY_INIT_EN = 6;
  localparam int SY_DECOMP = 7;
  localparam int SY_SECURE = 8;
  localparam int SY_W = 9;
  // the request line idles high, so its stage starts high as well
  localparam logic [SY_W-1:0] SY_RST_VAL = 9'h001;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_RESET = 3'b001,
    ST_DELAY = 3'b010,
    ST_RELEASE = 3'b011,
    ST_LOAD = 3'b100,
    ST_INIT = 3'b101,
    ST_USER = 3'b110,
    ST_ERROR = 3'b111
  } pcl_state_e;

  // open-drain pin drive: oe_n low pulls the line to o
  typedef struct packed {
    logic o;
    logic oe_n;
  } pcl_od_s;

  typedef struct packed {
    pcl_state_e state;
    logic [CNT_W-1:0] cnt;
    logic hold;
    logic decomp;
    logic secure;
    logic ready_drv;
    logic done_rel;
    logic init_drv;
    logic user;
  } pcl_sys_s;

  typedef struct packed {
    logic [3:0] phase;
    logic [WCNT_W-1:0] words;
    logic [DATA_W-1:0] sum;
    logic init_en;
    logic loaded;
    logic error;
  } pcl_link_s;

  // ratio lookup from the two load settings
  function automatic logic [3:0] pcl_ratio(input logic decomp, input logic secure);
    logic [3:0] r;
    r = RATIO_PLAIN;
    if (decomp && secure) begin
      r = RATIO_BOTH;
    end else if (decomp) begin
      r = RATIO_DECOMP;
    end else if (secure) begin
      r = RATIO_SECURE;
    end
    return r;
  endfunction

endpackage

// [pcl_sync.sv]
// two-flop level synchroniser, vector wide
`timescale 1ns/10ps
module pcl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk, // destination clock
  input wire logic rst, // async reset, active high
  input wire logic [WIDTH-1:0] d, // asynchronous levels
  output logic [WIDTH-1:0] q // synchronised levels
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  // ----------------------------------------------------------------
  // two stages; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule

// [pcl_loader_asserts.sv]
// concurrent checks on the loader's pins
`timescale 1ns/10ps
module pcl_loader_chk
  import pcl_pkg::*;
#(
  parameter int POR_DELAY_NS = 100000
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic cfg_request_n, // host request
  input wire logic cfg_ready_n_i, // ready line level
  input pcl_od_s cfg_ready_n_od, // ready drive
  input wire logic load_complete_i, // load-complete line level
  input pcl_od_s load_complete_od, // load-complete drive
  input pcl_od_s init_done_od, // init-done drive
  input wire logic user_mode, // user mode flag
  input wire logic user_io_oe_n // user i/o enable
);
  localparam int POR_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  int por_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // counts clk cycles since reset release, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) por_cnt <= 0;
    else if (por_cnt < POR_CYC) por_cnt <= por_cnt + 1;
  end
  a_por_ready_low: assert property (por_cnt < POR_CYC - 1 |-> !cfg_ready_n_od.oe_n)
    else $error("ready released during power-on delay");
  a_req_pulls_ready: assert property (!cfg_request_n [*5] |->
    !cfg_ready_n_od.oe_n)
    else $error("ready not pulled low on request");
  a_req_drops_user: assert property ($fell(cfg_request_n) && user_mode |->
    ##[1:5] !user_mode)
    else $error("user mode kept after request");
  a_user_lines_high: assert property (user_mode && cfg_request_n [*4] |->
    cfg_ready_n_od.oe_n && load_complete_od.oe_n)
    else $error("status lines low in user mode");
  a_done_after_load: assert property ($rose(load_complete_od.oe_n) |->
    $past(cfg_ready_n_od.oe_n) && !user_mode)
    else $error("load complete released outside loading");
  a_done_stays: assert property (cfg_request_n [*4] ##0 load_complete_od.oe_n |=>
    load_complete_od.oe_n)
    else $error("load complete dropped without request");
  a_init_wait: assert property ($rose(user_mode) |->
    $past(load_complete_od.oe_n, 8) && load_complete_i)
    else $error("user mode entered too early");
  a_user_io_hiz: assert property (user_io_oe_n == !user_mode)
    else $error("user io enable disagrees with mode");
  a_init_high: assert property (user_mode |-> init_done_od.oe_n)
    else $error("init done low in user mode");
  a_ready_release: assert property ($rose(cfg_request_n) ##1 por_cnt == POR_CYC |->
    (!cfg_ready_n_od.oe_n) [*8] ##[1:20] cfg_ready_n_od.oe_n)
    else $error("ready release timing wrong");
  a_done_ready_high: assert property ($rose(load_complete_od.oe_n) |->
    cfg_ready_n_i)
    else $error("load complete released while ready line low");
endmodule
bind pcl_loader pcl_loader_chk #(.POR_DELAY_NS(POR_DELAY_NS)) chk (.clk(clk), .rst(rst),
  .cfg_request_n(cfg_request_n), .cfg_ready_n_i(cfg_ready_n_i),
  .cfg_ready_n_od(cfg_ready_n_od), .load_complete_i(load_complete_i),
  .load_complete_od(load_complete_od), .init_done_od(init_done_od),
  .user_mode(user_mode), .user_io_oe_n(user_io_oe_n));

// [pcl_host.sv]
// host model: sends one bitstream frame per start pulse
`timescale 1ns/10ps
module pcl_host
  import pcl_pkg::*;
#(
  parameter int NW = 6
) (
  output logic cfg_clock, // link clock, still outside frames
  output logic [DATA_W-1:0] cfg_data, // word to the device
  input wire logic go, // start one frame
  input wire logic [3:0] ratio, // clocks per word
  input wire logic [DATA_W-1:0] base, // random word source
  input wire logic opt, // init-done enable bit
  input wire logic bad, // corrupt the check word
  input wire logic pause, // stall the clock mid-frame
  input wire logic lc, // load-complete line
  output logic busy // frame in progress
);
  logic [DATA_W-1:0] w;
  logic [DATA_W-1:0] sum;
  int i;
  // one 64 ns link clock period, rising first
  task automatic tick;
    #32 cfg_clock = 1'b1;
    #32 cfg_clock = 1'b0;
  endtask
  // whole stream, word held r clocks, data set before each rise; clock low between frames
  initial begin
    cfg_clock = 1'b0;
    cfg_data = '0;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      sum = '0;
      #3.3;
      for (int k = 0; k < NW; k++) begin
        w = base ^ DATA_W'(k * 32'h01000193);
        if (k == 0) w[OPT_INIT_DONE_BIT] = opt;
        if (k == NW - 1) w = sum ^ DATA_W'(bad);
        sum = sum ^ w;
        cfg_data = w;
        if (pause && k == 2) #500;
        for (int j = 0; j < ratio; j++) tick;
        cfg_data = ~w;
      end
      for (i = 0; i < 200 && lc !== 1'b1; i++) #32;
      // falls after load complete; no edges at all if load complete never rises
      if (lc === 1'b1) begin
        repeat (6) tick;
      end
      busy = 1'b0;
    end
  end
endmodule

// [tb.sv]
// self-checking bench for the parallel configuration loader
`timescale 1ns/10ps
module tb;
  import pcl_pkg::*;
  localparam int NW = 6;
  logic clk = 0, rst = 1, cfg_request_n = 1, dec = 0, sec = 0;
  logic go = 0, opt = 0, bad = 0, pause = 0, cfg_clock, busy, user_mode, user_io_oe_n;
  logic ready_line, done_line, init_line;
  logic [3:0] ratio = 4'h1;
  logic [DATA_W-1:0] base = '0, cfg_data;
  pcl_od_s ready_od, done_od, init_od;
  int seed = 35, miscompares = 0, n_tests = 0, i;
  always #2.5 clk = ~clk;
  // open-drain lines with pull-ups
  assign ready_line = ready_od.oe_n ? 1'b1 : ready_od.o;
  assign done_line = done_od.oe_n ? 1'b1 : done_od.o;
  assign init_line = init_od.oe_n ? 1'b1 : init_od.o;
  pcl_loader #(.NUM_WORDS(NW), .POR_DELAY_NS(100), .RST_DELAY_NS(50), .INIT_CYCLES(8)) uut (
    .clk(clk), .rst(rst), .cfg_clock(cfg_clock), .cfg_request_n(cfg_request_n),
    .cfg_data(cfg_data), .cfg_decompress(dec), .cfg_secure(sec), .cfg_ready_n_i(ready_line),
    .cfg_ready_n_od(ready_od), .load_complete_i(done_line), .load_complete_od(done_od),
    .init_done_od(init_od), .user_mode(user_mode), .user_io_oe_n(user_io_oe_n));
  pcl_host #(.NW(NW)) host (.cfg_clock(cfg_clock), .cfg_data(cfg_data), .go(go),
    .ratio(ratio), .base(base), .opt(opt), .bad(bad), .pause(pause), .lc(done_line),
    .busy(busy));
  task automatic check(input string what, input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      $display("mismatch %s expected %b seen %b", what, exp, seen);
      miscompares++;
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      finish_test;
    end
  endtask
  function automatic logic [3:0] exp_ratio(input logic d, input logic s);
    return d ? (s ? RATIO_BOTH : RATIO_DECOMP) : (s ? RATIO_SECURE : RATIO_PLAIN);
  endfunction
  // request, wait for ready, send a frame, check the outcome
  task automatic frame(input logic d, input logic s, input logic b, input logic p);
    dec = d;
    sec = s;
    bad = b;
    pause = p;
    opt = 1'($random(seed));
    base = $random(seed);
    ratio = exp_ratio(d, s);
    cfg_request_n = 1'b0;
    repeat (6) @(negedge clk);
    cfg_request_n = 1'b1;
    for (i = 0; i < 400 && ready_line !== 1'b1; i++) @(negedge clk);
    bound(i, 400);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    if (!b) begin
      for (i = 0; i < 4000 && done_line !== 1'b1; i++) @(negedge clk);
      bound(i, 4000);
      repeat (2) @(negedge clk);
      check("init_done_load", init_line, !opt);
      check("user_mode_early", user_mode, 1'b0);
    end
    for (i = 0; i < 6000 && busy !== 1'b0; i++) @(negedge clk);
    bound(i, 6000);
    repeat (4) @(negedge clk);
    check("load_complete", done_line, !b);
    check("ready", ready_line, !b);
    check("user_mode", user_mode, !b);
    check("user_io_oe_n", user_io_oe_n, b);
    if (!b) check("init_done_user", init_line, 1'b1);
  endtask
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    check("ready_por", ready_line, 1'b0);
    check("load_complete_por", done_line, 1'b0);
    check("user_io_por", user_io_oe_n, 1'b1);
    for (int k = 0; k < 4; k++) frame(k[1], k[0], 1'b0, k == 3);
    frame(1'b0, 1'b1, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) frame(1'($random(seed)), 1'($random(seed)), 1'b0, k[0]);
    cfg_request_n = 1'b0;
    repeat (6) @(negedge clk);
    check("user_mode_req", user_mode, 1'b0);
    check("load_complete_req", done_line, 1'b0);
    cfg_request_n = 1'b1;
    finish_test;
  end
endmodule
